//--- dv/gpt_core_properties.sv
// Port assertions of the timer core
`timescale 1ns/10ps
module gpt_core_properties (
	input wire logic        core_clk,
	input wire logic        arst_n,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        captureOut,
	input wire logic        captureOe,
	input wire logic        compareOut,
	input wire logic        pwmOut,
	input wire logic        irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	wire rdReq = hsel && htrans[1] && hready && !hwrite;
	wire wrReq = hsel && htrans[1] && hready && hwrite;
	////////////////////////////////////////////////////////////////////////
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready and okay");
	a_rdata_idle: assert property (hrdata != 32'h0 |-> $past(rdReq))
		else $error("read data outside a read data phase");
	a_write_quiet: assert property (wrReq |=> hrdata == 32'h0)
		else $error("read data during a write");
	a_irq_clear: assert property ($fell(irq) |-> $past(wrReq, 2))
		else $error("interrupt dropped without a write");
	a_gpo_write: assert property (($changed(captureOe)
		|| $changed(captureOut)) |-> $past(wrReq, 2))
		else $error("capture pin drive changed without a write");
	a_pwm_high: assert property ($rose(pwmOut) |=> pwmOut[*3])
		else $error("pwm high shorter than one step");
	a_pwm_low: assert property ($fell(pwmOut) |=> !pwmOut[*3])
		else $error("pwm low shorter than one step");
	a_cmp_hold: assert property ($changed(compareOut)
		|=> $stable(compareOut)[*3])
		else $error("compare pin changed twice in one step");
	////////////////////////////////////////////////////////////////////////
	c_irq: cover property ($rose(irq));
	c_pwm: cover property ($rose(pwmOut));
	c_cmp: cover property ($changed(compareOut));
endmodule

//--- dv/gpt_core_tb_top.sv
// Self-checking bench of the timer core
`timescale 1ns/10ps
module gpt_core_tb_top;
	import gpt_pkg::*;
	logic        core_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        hreadyout, hresp, paIn, capIn, captureOut, captureOe;
	logic        compareOut, pwmOut, irq;
	logic [31:0] hrdata, d, v;
	int          failures = 0;
	int          total_checks = 0;
	int          cycles = 0;
	int          acc, n;
	always #5 core_clk = ~core_clk;
	gpt_core #(.FILT_LEN(2)) u_dut (
		.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .pulseAccumInput(paIn), .captureIn(capIn),
		.captureOut(captureOut), .captureOe(captureOe),
		.compareOut(compareOut), .pwmOut(pwmOut), .irq(irq));
	gpt_pin_model u_pins (.core_clk(core_clk), .captureOut(captureOut),
		.captureOe(captureOe), .pulseAccumInput(paIn), .captureIn(capIn));
	////////////////////////////////////////////////////////////////////////
	task automatic bus(input bit wr, input logic [5:0] i,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, i, 2'h0};
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [5:0] i, input logic [31:0] e);
		bus(1'b0, i, 32'h0, d);
		chk(d, e);
	endtask
	task automatic wr(input logic [5:0] i, input logic [31:0] val);
		bus(1'b1, i, val, d);
	endtask
	task automatic end_sim;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			failures++;
			end_sim;
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		d = $urandom(32'he571);
		repeat (3) @(posedge core_clk);
		arst_n <= 1'b1;
		rdc(IDX_CTRL, 32'h0);
		wr(IDX_STATUS, 32'h1f);
		rdc(IDX_STATUS, 32'h0);
		rdc(6'h0f, 32'h0);
		for (n = 0; n < 4; n++)
		begin
			v = $urandom;
			wr(IDX_COMPARE, v);
			rdc(IDX_COMPARE, v & 32'hffff);
		end
		wr(IDX_COMPARE, 32'hffff);
		bus(1'b0, IDX_COUNT, 32'h0, v);
		repeat (37) @(posedge core_clk);
		bus(1'b0, IDX_COUNT, 32'h0, d);
		chk((d - v) & 32'hffff, 32'ha);
		$display("test registers and counter done");
		wr(IDX_ACCUM, 32'hfe);
		wr(IDX_CTRL, 32'h1);
		acc = 8'hfe;
		repeat (2)
		begin
			u_pins.pulse(1'b0, 6, 6);
			acc = (acc + 1) & 8'hff;
		end
		u_pins.pulse(1'b0, 1, 8);
		rdc(IDX_ACCUM, acc);
		rdc(IDX_STATUS, 32'h3);
		rdc(IDX_STATUS, 32'h3);
		wr(IDX_CLEAR, 32'h3);
		rdc(IDX_STATUS, 32'h0);
		wr(IDX_ACCUM, 32'h0);
		wr(IDX_CTRL, 32'h3);
		u_pins.pulse(1'b0, 40, 8);
		acc = 40 / 4;
		bus(1'b0, IDX_ACCUM, 32'h0, d);
		chk(d >= acc - 1 && d <= acc + 1, 32'h1);
		rdc(IDX_STATUS, 32'h1);
		wr(IDX_CLEAR, 32'h1f);
		wr(IDX_ACCUM, 32'h0);
		wr(IDX_CTRL, 32'h5);
		u_pins.pulse(1'b0, 6, 6);
		rdc(IDX_ACCUM, 32'h1);
		rdc(IDX_STATUS, 32'h1);
		$display("test accumulator done");
		wr(IDX_CLEAR, 32'h1f);
		wr(IDX_CTRL, 32'h10);
		bus(1'b0, IDX_COUNT, 32'h0, v);
		u_pins.pulse(1'b1, 6, 6);
		bus(1'b0, IDX_CAPTURE, 32'h0, d);
		chk(((d - v) & 32'hffff) <= 3, 32'h1);
		rdc(IDX_STATUS, 32'h8);
		wr(IDX_CLEAR, 32'h1f);
		wr(IDX_CTRL, 32'h310);
		repeat (8) @(posedge core_clk);
		chk({30'h0, captureOe, captureOut}, 32'h3);
		rdc(IDX_STATUS, 32'h8);
		wr(IDX_CLEAR, 32'h1f);
		wr(IDX_CTRL, 32'h120);
		repeat (8) @(posedge core_clk);
		rdc(IDX_STATUS, 32'h8);
		wr(IDX_CTRL, 32'h0);
		wr(IDX_CLEAR, 32'h1f);
		$display("test capture done");
		wr(IDX_IRQEN, 32'h4);
		bus(1'b0, IDX_COUNT, 32'h0, v);
		wr(IDX_COMPARE, v + 32'h8);
		wr(IDX_CTRL, 32'h40);
		for (n = 0; n < 200 && irq !== 1'b1; n++)
			@(negedge core_clk);
		chk(irq, 1'b1);
		chk(compareOut, 1'b0);
		@(negedge core_clk);
		chk(compareOut, 1'b1);
		wr(IDX_IRQEN, 32'h0);
		@(negedge core_clk);
		chk(irq, 1'b0);
		rdc(IDX_STATUS, 32'h4);
		wr(IDX_CLEAR, 32'h4);
		rdc(IDX_STATUS, 32'h0);
		$display("test compare done");
		v = 1 + $urandom % 8;
		wr(IDX_DUTY, v);
		wr(IDX_CTRL, 32'h400);
		for (n = 0; n < 1100 && pwmOut !== 1'b1; n++)
			@(negedge core_clk);
		for (n = 0; n < 100 && pwmOut === 1'b1; n++)
			@(negedge core_clk);
		chk(n, 4 * v);
		$display("test pwm done");
		end_sim;
	end
endmodule
bind gpt_core gpt_core_properties u_props (
	.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .captureOut(captureOut),
	.captureOe(captureOe), .compareOut(compareOut), .pwmOut(pwmOut),
	.irq(irq));

//--- dv/gpt_pin_model.sv
// Far side pin model for accumulator and capture pins
`timescale 1ns/10ps
module gpt_pin_model (
	input  wire logic core_clk,
	input  wire logic captureOut,
	input  wire logic captureOe,
	output logic      pulseAccumInput,
	output logic      captureIn
);
	logic paLvl = 1'b0;
	logic capLvl = 1'b0;
	assign captureIn = captureOe ? captureOut : capLvl;
	assign pulseAccumInput = paLvl;
	// Pulse on one pin, high then low
	task automatic pulse(input bit cap, input int hi, input int lo);
		@(posedge core_clk);
		if (cap)
			capLvl <= 1'b1;
		else
			paLvl <= 1'b1;
		repeat (hi) @(posedge core_clk);
		capLvl <= 1'b0;
		paLvl <= 1'b0;
		repeat (lo) @(posedge core_clk);
	endtask
endmodule

//--- src/gpt_core.sv
// General purpose timer core with an AHB-Lite register slave
// Notes on behaviour
// - Accumulator and capture inputs are synchronised, then filtered.
// - All timer logic runs on the one phase clock, core_clk.
// - The free running counter steps on every fourth clock.
// - Event mode: each leading edge counts and sets the edge flag.
// - Accumulator wrap from ff to 00 sets the overflow flag.
// - Gated mode: the accumulator counts on quarter-rate ticks while gated.
// - Gated mode: the edge flag is set when the input is negated.
// - With wrap clocking, gated counting steps on each counter wrap.
// - With a nonzero duty value, the PWM pin goes high when the PWM counter wraps to zero.
// - The PWM pin goes low when the PWM counter equals the duty value.
// - A compare match sets its flag, and the pin action follows later.
// - A selected capture edge latches the counter and sets the flag.
// - A capture pin driven as output feeds its own input conditioner.
//
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
module gpt_core
	import gpt_pkg::*;
#(
	parameter int FILT_LEN = gpt_pkg::FILT_CYCLES
)
(
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        pulseAccumInput,
	input  wire logic        captureIn,
	output logic             captureOut,
	output logic             captureOe,
	output logic             compareOut,
	output logic             pwmOut,
	output logic             irq
);
	import gpt_pkg::*;

	gpt_state_t s;
	gpt_state_t n;

	logic        tick;
	logic [15:0] frcNext;
	logic        frcWrap;
	logic        paLevel;
	logic        paLevelNext;
	logic        paLead;
	logic        paNegate;
	logic        paStep;
	logic [7:0]  paNew;
	logic        cpRise;
	logic        cpFall;
	logic        capHit;
	logic        cmpHit;
	logic        pwmWrap;
	logic        cpSource;
	logic        apTake;
	logic        dpWrite;
	logic [STAT_W-1:0] events;
	logic [STAT_W-1:0] clearMask;
	logic [FILT_W:0]   paF;
	logic [FILT_W:0]   cpF;

	////////////////////////////////////////////////////////////////////
	// Filter step: output follows input after FILT_LEN stable cycles
	function automatic logic [FILT_W:0] filtStep(
		input logic              syncIn,
		input logic              filtOut,
		input logic [FILT_W-1:0] cnt
	);
		logic [FILT_W:0] r;
		r = {filtOut, {FILT_W{1'b0}}};
		if (syncIn != filtOut)
		begin
			if (cnt >= FILT_W'(FILT_LEN - 1))
				r = {syncIn, {FILT_W{1'b0}}};
			else
				r = {filtOut, FILT_W'(cnt + 1'b1)};
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Byte counter step, wrapping past ff
	function automatic logic [7:0] byteStep(
		input logic       en,
		input logic [7:0] val
	);
		logic [7:0] r;
		r = val;
		if (en)
			r = 8'(val + 1'b1);
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Counter step on the quarter tick
	function automatic logic [15:0] wordStep(
		input logic        en,
		input logic [15:0] val
	);
		logic [15:0] r;
		r = val;
		if (en)
			r = 16'(val + 1'b1);
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Edge from old and new level, rising or falling
	function automatic logic edgeOf(
		input logic oldLvl,
		input logic newLvl,
		input logic rising
	);
		logic r;
		r = rising ? (newLvl && !oldLvl) : (!newLvl && oldLvl);
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Sticky flag update, a set wins over a same cycle clear
	function automatic logic [STAT_W-1:0] stickyNext(
		input logic [STAT_W-1:0] cur,
		input logic [STAT_W-1:0] clr,
		input logic [STAT_W-1:0] set
	);
		logic [STAT_W-1:0] r;
		r = (cur & ~clr) | set;
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Compare pin level after the selected action
	function automatic logic pinAction(
		input logic [1:0] act,
		input logic       cur
	);
		logic r;
		r = cur;
		unique case (act)
			ACT_NONE:   r = cur;
			ACT_TOGGLE: r = !cur;
			ACT_CLEAR:  r = 1'b0;
			ACT_SET:    r = 1'b1;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Read value of one register word
	function automatic logic [31:0] readWord(
		input logic [ADDR_W-1:0] idx,
		input gpt_state_t        st
	);
		logic [31:0] r;
		r = '0;
		unique case (idx)
			IDX_CTRL:    r = 32'(st.ctrl);
			IDX_COUNT:   r = 32'(st.frc);
			IDX_ACCUM:   r = 32'(st.paCount);
			IDX_COMPARE: r = 32'(st.compareVal);
			IDX_CAPTURE: r = 32'(st.captureVal);
			IDX_DUTY:    r = 32'(st.pwmDuty);
			IDX_STATUS:  r = 32'(st.status);
			IDX_IRQEN:   r = 32'(st.irqEn);
			default:     r = '0;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Accumulator count enable for the selected mode
	function automatic logic accumStep(
		input logic [CTRL_W-1:0] ctl,
		input logic              lead,
		input logic              level,
		input logic              qtick,
		input logic              wrap
	);
		logic r;
		r = 1'b0;
		if (ctl[C_PA_EN])
		begin
			if (!ctl[C_PA_GATED])
				r = lead;
			else if (!ctl[C_PA_WRAPCLK])
				r = qtick && level;
			else
				r = wrap && level;
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		n = s;
		clearMask = '0;

		// Bus address phase capture
		apTake = hsel && htrans[1] && hready;
		dpWrite = s.apSel && s.apWrite;
		n.apSel = apTake;
		n.apWrite = hwrite;
		n.apAddr = haddr[ADDR_W+1:2];

		n.prescale = 2'(s.prescale + 1'b1);
		tick = (s.prescale == PRESCALE_LAST);

		frcWrap = tick && (s.frc == FRC_MAX);
		frcNext = wordStep(tick, s.frc);
		n.frc = frcNext;

		n.paSync1 = pulseAccumInput;
		n.paSync2 = s.paSync1;
		paF = filtStep(s.paSync2, s.paFilt, s.paFcnt);
		n.paFilt = paF[FILT_W];
		n.paFcnt = paF[FILT_W-1:0];

		cpSource = s.ctrl[C_GPO_EN] ? s.ctrl[C_GPO_VAL] : captureIn;
		n.cpSync1 = cpSource;
		n.cpSync2 = s.cpSync1;
		cpF = filtStep(s.cpSync2, s.cpFilt, s.cpFcnt);
		n.cpFilt = cpF[FILT_W];
		n.cpFcnt = cpF[FILT_W-1:0];

		// Asserted level per selected polarity
		paLevel = s.paFilt ^ s.ctrl[C_PA_FALL];
		paLevelNext = n.paFilt ^ s.ctrl[C_PA_FALL];
		paLead = edgeOf(paLevel, paLevelNext, 1'b1);
		paNegate = edgeOf(paLevel, paLevelNext, 1'b0);

		// Accumulator step for the mode
		paStep = accumStep(s.ctrl, paLead, paLevel, tick, frcWrap);
		paNew = byteStep(paStep, s.paCount);
		n.paCount = paNew;

		pwmWrap = tick && (s.pwmCnt == BYTE_MAX);
		n.pwmCnt = byteStep(tick, s.pwmCnt);
		if (!s.ctrl[C_PWM_EN])
			n.pwmOut = 1'b0;
		else if (tick && (n.pwmCnt == s.pwmDuty))
			n.pwmOut = 1'b0;
		else if (pwmWrap)
			n.pwmOut = 1'b1;

		// Flag now, pin action next cycle
		cmpHit = tick && (frcNext == s.compareVal);
		n.cmpPend = cmpHit;
		if (s.cmpPend)
			n.cmpOut = pinAction(s.ctrl[C_CMP_ACT_LO +: 2], s.cmpOut);

		cpRise = edgeOf(s.cpFilt, n.cpFilt, 1'b1);
		cpFall = edgeOf(s.cpFilt, n.cpFilt, 1'b0);
		capHit = (cpRise && s.ctrl[C_CAP_RISE])
			|| (cpFall && s.ctrl[C_CAP_FALL]);
		if (capHit)
			n.captureVal = s.frc;

		// Event vector
		events = '0;
		events[S_PA_EDGE] = s.ctrl[C_PA_EN] && !s.ctrl[C_PA_GATED] && paLead;
		if (s.ctrl[C_PA_EN] && s.ctrl[C_PA_GATED])
			events[S_PA_EDGE] = paNegate;
		events[S_PA_OVF] = paStep && (s.paCount == BYTE_MAX)
			&& (paNew == BYTE_ZERO);
		events[S_CMP] = cmpHit;
		events[S_CAP] = capHit;
		events[S_WRAP] = frcWrap;

		// Register writes in data phase
		if (dpWrite)
		begin
			unique case (s.apAddr)
				IDX_CTRL:    n.ctrl = hwdata[CTRL_W-1:0];
				IDX_ACCUM:   n.paCount = hwdata[7:0];
				IDX_COMPARE: n.compareVal = hwdata[15:0];
				IDX_DUTY:    n.pwmDuty = hwdata[7:0];
				IDX_CLEAR:   clearMask = hwdata[STAT_W-1:0];
				IDX_IRQEN:   n.irqEn = hwdata[STAT_W-1:0];
				default:     n.ctrl = n.ctrl;
			endcase
		end

		// Sticky flags, set wins over clear
		n.status = stickyNext(s.status, clearMask, events);

		// Read data registered at address phase
		n.rdata = '0;
		if (apTake && !hwrite)
			n.rdata = readWord(haddr[ADDR_W+1:2], n);
	end

	////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s <= '0;
			s.ctrl <= CTRL_RESET;
		end
		else
			s <= n;
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s.rdata;
	assign captureOut = s.ctrl[C_GPO_VAL];
	assign captureOe = s.ctrl[C_GPO_EN];
	assign compareOut = s.cmpOut;
	assign pwmOut = s.pwmOut;
	assign irq = |(s.status & s.irqEn);

	// Unused bus inputs
	logic unusedBits;
	assign unusedBits = ^{hsize, haddr[31:ADDR_W+2], haddr[1:0]};

endmodule

//--- src/gpt_pkg.sv
// Constants and state type of the general purpose timer core
package gpt_pkg;
	localparam int            FILT_CYCLES    = 2;
	localparam int            FILT_W         = 3;
	localparam logic [1:0]    PRESCALE_LAST  = 2'h3;
	localparam logic [15:0]   FRC_MAX        = 16'hffff;
	localparam logic [7:0]    BYTE_MAX       = 8'hff;
	localparam logic [7:0]    BYTE_ZERO      = 8'h00;
	localparam int            ADDR_W         = 6;
	// Word indexes; byte address is four times the index
	localparam logic [5:0]    IDX_CTRL       = 6'h00;
	localparam logic [5:0]    IDX_COUNT      = 6'h01;
	localparam logic [5:0]    IDX_ACCUM      = 6'h02;
	localparam logic [5:0]    IDX_COMPARE    = 6'h03;
	localparam logic [5:0]    IDX_CAPTURE    = 6'h04;
	localparam logic [5:0]    IDX_DUTY       = 6'h05;
	localparam logic [5:0]    IDX_STATUS     = 6'h06;
	localparam logic [5:0]    IDX_CLEAR      = 6'h07;
	localparam logic [5:0]    IDX_IRQEN      = 6'h08;
	// Control bit positions
	localparam int            C_PA_EN        = 0;
	localparam int            C_PA_GATED     = 1;
	localparam int            C_PA_FALL      = 2;
	localparam int            C_PA_WRAPCLK   = 3;
	localparam int            C_CAP_RISE     = 4;
	localparam int            C_CAP_FALL     = 5;
	localparam int            C_CMP_ACT_LO   = 6;
	localparam int            C_GPO_EN       = 8;
	localparam int            C_GPO_VAL      = 9;
	localparam int            C_PWM_EN       = 10;
	localparam int            CTRL_W         = 11;
	localparam logic [10:0]   CTRL_RESET     = 11'h000;
	// Compare pin actions
	localparam logic [1:0]    ACT_NONE       = 2'h0;
	localparam logic [1:0]    ACT_TOGGLE     = 2'h1;
	localparam logic [1:0]    ACT_CLEAR      = 2'h2;
	localparam logic [1:0]    ACT_SET        = 2'h3;
	// Status bit positions
	localparam int            S_PA_EDGE      = 0;
	localparam int            S_PA_OVF       = 1;
	localparam int            S_CMP          = 2;
	localparam int            S_CAP          = 3;
	localparam int            S_WRAP         = 4;
	localparam int            STAT_W         = 5;

	typedef struct packed {
		logic [1:0]          prescale;
		logic [15:0]         frc;
		logic [7:0]          paCount;
		logic [7:0]          pwmCnt;
		logic                pwmOut;
		logic [15:0]         compareVal;
		logic [15:0]         captureVal;
		logic [7:0]          pwmDuty;
		logic [CTRL_W-1:0]   ctrl;
		logic [STAT_W-1:0]   status;
		logic [STAT_W-1:0]   irqEn;
		logic                cmpPend;
		logic                cmpOut;
		logic                paSync1;
		logic                paSync2;
		logic                paFilt;
		logic [FILT_W-1:0]   paFcnt;
		logic                cpSync1;
		logic                cpSync2;
		logic                cpFilt;
		logic [FILT_W-1:0]   cpFcnt;
		logic                apSel;
		logic                apWrite;
		logic [ADDR_W-1:0]   apAddr;
		logic [31:0]         rdata;
	} gpt_state_t;
endpackage
